/* File: dmac_chan.v */
// DMAC channel: programmed settings and running address/count state.
// Assumes the engine pulses step/fail in the cycle a transfer ends.
`timescale 1ns/1ps
`include "dmac_consts.vh"

module dmac_chan #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Register writes, word index within the channel
  input wire wr_en,
  input wire [2:0] wr_idx,
  input wire [31:0] wr_data,
  // Engine handshake
  input wire step,
  input wire fail,
  // Programmed settings
  output reg [31:0] src_q,
  output reg [31:0] dst_q,
  output reg [CNT_W-1:0] cnt_q,
  output reg [3:0] cfg_q,
  // Running job state
  output reg [31:0] cur_src_q,
  output reg [31:0] cur_dst_q,
  output reg [CNT_W-1:0] rem_q,
  output reg [3:0] run_cfg_q,
  output reg active_q
);

  // Address step by transfer unit; unused size code steps as a word
  function [31:0] incr;
    input [31:0] a;
    input [1:0] sz;
    begin
      case (sz)
        `DMAC_SZ_BYTE: incr = a + 32'h1;
        `DMAC_SZ_HALF: incr = a + 32'h2;
        default: incr = a + 32'h4;
      endcase
    end
  endfunction

  wire go;
  assign go = wr_en && (wr_idx == `DMAC_R_CTL) && wr_data[`DMAC_CTL_GO] && !active_q;

  // Settings registers and job state
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      src_q <= 32'h0;
      dst_q <= 32'h0;
      cnt_q <= {CNT_W{1'b0}};
      cfg_q <= `DMAC_CFG_RST;
      cur_src_q <= 32'h0;
      cur_dst_q <= 32'h0;
      rem_q <= {CNT_W{1'b0}};
      run_cfg_q <= `DMAC_CFG_RST;
      active_q <= 1'b0;
    end
    else
    begin
      // Settings may change while a job runs; the job keeps its copy
      if (wr_en && wr_idx == `DMAC_R_SRC)
        src_q <= wr_data;
      if (wr_en && wr_idx == `DMAC_R_DST)
        dst_q <= wr_data;
      if (wr_en && wr_idx == `DMAC_R_CNT)
        cnt_q <= wr_data[CNT_W-1:0];
      if (wr_en && wr_idx == `DMAC_R_CFG)
        cfg_q <= wr_data[3:0];
      // R9: software bit starts job
      // R18: settings sampled at start
      if (go)
      begin
        cur_src_q <= src_q;
        cur_dst_q <= dst_q;
        rem_q <= cnt_q;
        run_cfg_q <= cfg_q;
        active_q <= 1'b1;
      end
      // R19: error stops the job
      else if (fail)
        active_q <= 1'b0;
      // R5: count down remaining transfers
      else if (step)
      begin
        if (rem_q == {CNT_W{1'b0}})
          active_q <= 1'b0;
        else
          rem_q <= rem_q - {{(CNT_W-1){1'b0}}, 1'b1};
        // R6: advance by transfer unit
        cur_src_q <= incr(cur_src_q, run_cfg_q[`DMAC_CFG_SZ_HI:0]);
        cur_dst_q <= incr(cur_dst_q, run_cfg_q[`DMAC_CFG_SZ_HI:0]);
      end
    end
  end

endmodule // dmac_chan

/* File: dmac_consts.vh */
// DMAC constants: register map, field positions, encodings, reset values.
// Included by dmac_chan.v and dmac_top.v; definitions only.
`ifndef DMAC_CONSTS_VH
`define DMAC_CONSTS_VH
// Address decode: bit 6 selects global block, bit 5 selects channel
`define DMAC_GLB_SEL 6
`define DMAC_CH_SEL 5
`define DMAC_MAP_LO 7
// Per-channel word index (haddr[4:2])
`define DMAC_R_SRC 3'h0
`define DMAC_R_DST 3'h1
`define DMAC_R_CNT 3'h2
`define DMAC_R_CFG 3'h3
`define DMAC_R_CTL 3'h4
`define DMAC_R_REM 3'h5
// Global word index (haddr[4:2])
`define DMAC_G_MODE 3'h0
`define DMAC_G_STAT 3'h1
`define DMAC_G_MASK 3'h2
`define DMAC_G_BUSY 3'h3
// Channel configuration fields
`define DMAC_CFG_RST 4'h0
`define DMAC_CFG_SZ_HI 1
`define DMAC_CFG_BURST 2
`define DMAC_CFG_EXT 3
`define DMAC_SZ_BYTE 2'h0
`define DMAC_SZ_HALF 2'h1
`define DMAC_SZ_WORD 2'h2
// Control and mode bits
`define DMAC_CTL_GO 0
`define DMAC_MODE_RR 0
// Status / mask layout: two bits per channel
`define DMAC_ST_DONE 0
`define DMAC_ST_ERR 1
`define DMAC_ST_RST 4'h0
`define DMAC_MASK_RST 4'h0
// Engine states
`define DMAC_S_IDLE 3'h0
`define DMAC_S_GRANT 3'h1
`define DMAC_S_READ 3'h2
`define DMAC_S_WRITE 3'h3
`endif

/* File: dmac_sys_model.sv */
// Model of the system bus arbiter and memory behind the engine.
// Assumes one requester; latency is set live by the bench.
`timescale 1ns/1ps
module dmac_sys_model #(
  parameter ERR_ADDR = 32'hEEEE0000
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Bench control
  input wire [3:0] ack_dly,
  // Engine side
  input wire bus_req,
  input wire mem_req,
  input wire [31:0] mem_addr,
  output reg bus_grant,
  output reg mem_ack,
  output reg mem_err,
  output reg [31:0] mem_rdata
);
  reg [3:0] wait_q;
  // Grant trails request by a cycle; data is only valid with the ack
  always @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      bus_grant <= 1'b0;
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= 32'h0;
      wait_q <= 4'h0;
    end
    else
    begin
      bus_grant <= bus_req;
      mem_ack <= 1'b0;
      mem_err <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && wait_q == ack_dly)
      begin
        mem_ack <= 1'b1;
        mem_err <= (mem_addr == ERR_ADDR);
        mem_rdata <= mem_addr ^ 32'h5A5A0000;
        wait_q <= 4'h0;
      end
      else if (mem_req && !mem_ack) wait_q <= wait_q + 4'h1;
    end
endmodule // dmac_sys_model

/* File: dmac_top.v */
// DMAC top: AHB-Lite register slave, channel arbiter, dual-address
// transfer engine, external request pins and interrupt logic.
// Assumes one AHB-Lite master, a system bus arbiter answering bus_req
// with bus_grant, and a memory port that acks each access in one pulse.
`timescale 1ns/1ps
`include "dmac_consts.vh"

// Notes on behaviour
// R1: two independent channels, zero and one
// R2: moves memory or I/O to either
// R3: fixed mode: channel zero wins ties
// R4: round robin: last served drops lowest
// R5: up to 65,536 transfers per job
// R6: byte, half or word unit steps
// R7: cycle steal: request per transfer only
// R8: burst: request held until job ends
// R9: software request bit starts the job
// R10: external mode paced by own input
// R11: job completion raises channel interrupt
// R12: transfer error raises interrupt and flag
// R13: separate interrupt output per channel
// R14: per-channel mask gates only interrupt
// R15: device holds request high to ask
// R16: clear pulse acknowledges, device drops request
// R17: last-transfer output marks final transfer start
// R18: settings sampled when the job starts
// R19: stop on count exhausted or error
module dmac_top #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // AHB-Lite register slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // System bus request and transfer port
  output reg bus_req,
  input wire bus_grant,
  output reg mem_req,
  output reg mem_write,
  output reg [31:0] mem_addr,
  output reg [1:0] mem_size,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire mem_err,
  input wire [31:0] mem_rdata,
  // External DMA device pins
  input wire chan0_ext_request_in,
  input wire chan1_ext_request_in,
  output reg chan0_request_clear_out,
  output reg chan1_request_clear_out,
  output reg chan0_last_transfer_out,
  output reg chan1_last_transfer_out,
  // Interrupts
  output reg chan0_irq,
  output reg chan1_irq,
  output reg irq
);

  reg [2:0] st_q;
  reg sel_q;
  reg last_srv_q;
  reg rr_q;
  reg [3:0] stat_q;
  reg [3:0] mask_q;
  reg [31:0] data_q;
  reg wr_pend_q;
  reg [4:0] ap_idx_q;
  reg [1:0] req_m_q;
  reg [1:0] req_s_q;
  reg [1:0] wlow_q;
  reg [31:0] rd_val;
  wire [31:0] src0, dst0, csrc0, cdst0, src1, dst1, csrc1, cdst1;
  wire [CNT_W-1:0] cnt0, rem0, cnt1, rem1;
  wire [3:0] cfg0, rcfg0, cfg1, rcfg1;
  wire act0, act1;
  wire wr_hit, wr_ch0, wr_ch1, ap_take;
  wire ok0, ok1, p0, p1, pick1, ok_sel;
  wire xfer_end, fail_now, step0, step1, fail0, fail1;
  wire last_sel, burst_sel, ext_sel;
  wire [31:0] csrc_sel, cdst_sel;
  wire [1:0] size_sel;
  wire [3:0] ev;

  // AHB address phase accepted; only NONSEQ/SEQ transfers count
  assign ap_take = hsel && hready && htrans[1];
  // Data-phase write decode
  assign wr_hit = wr_pend_q && !ap_idx_q[4];
  assign wr_ch0 = wr_hit && !ap_idx_q[3];
  assign wr_ch1 = wr_hit && ap_idx_q[3];

  // R1: two independent channels
  dmac_chan #(
    .CNT_W(CNT_W)
  ) u_ch0 (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(wr_ch0),
    .wr_idx(ap_idx_q[2:0]),
    .wr_data(hwdata),
    .step(step0),
    .fail(fail0),
    .src_q(src0),
    .dst_q(dst0),
    .cnt_q(cnt0),
    .cfg_q(cfg0),
    .cur_src_q(csrc0),
    .cur_dst_q(cdst0),
    .rem_q(rem0),
    .run_cfg_q(rcfg0),
    .active_q(act0)
  );

  dmac_chan #(
    .CNT_W(CNT_W)
  ) u_ch1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr_en(wr_ch1),
    .wr_idx(ap_idx_q[2:0]),
    .wr_data(hwdata),
    .step(step1),
    .fail(fail1),
    .src_q(src1),
    .dst_q(dst1),
    .cnt_q(cnt1),
    .cfg_q(cfg1),
    .cur_src_q(csrc1),
    .cur_dst_q(cdst1),
    .rem_q(rem1),
    .run_cfg_q(rcfg1),
    .active_q(act1)
  );

  // R10: external channels wait on their own synced request
  // R15: request honoured only in external mode
  assign ok0 = !rcfg0[`DMAC_CFG_EXT] || (req_s_q[0] && !wlow_q[0]);
  assign ok1 = !rcfg1[`DMAC_CFG_EXT] || (req_s_q[1] && !wlow_q[1]);
  assign p0 = act0 && ok0;
  assign p1 = act1 && ok1;
  // R3: channel zero first in fixed mode
  // R4: last served channel yields in round robin
  assign pick1 = p1 && (!p0 || (rr_q && !last_srv_q));

  // Selected channel view
  assign csrc_sel = sel_q ? csrc1 : csrc0;
  assign cdst_sel = sel_q ? cdst1 : cdst0;
  assign size_sel = sel_q ? rcfg1[`DMAC_CFG_SZ_HI:0] : rcfg0[`DMAC_CFG_SZ_HI:0];
  assign burst_sel = sel_q ? rcfg1[`DMAC_CFG_BURST] : rcfg0[`DMAC_CFG_BURST];
  assign ext_sel = sel_q ? rcfg1[`DMAC_CFG_EXT] : rcfg0[`DMAC_CFG_EXT];
  assign last_sel = sel_q ? (rem1 == {CNT_W{1'b0}}) : (rem0 == {CNT_W{1'b0}});
  assign ok_sel = sel_q ? ok1 : ok0;

  // Transfer ends on the write ack; an error on either ack fails it
  assign fail_now = mem_ack && mem_err && (st_q == `DMAC_S_READ || st_q == `DMAC_S_WRITE);
  assign xfer_end = mem_ack && !mem_err && st_q == `DMAC_S_WRITE;
  assign step0 = xfer_end && !sel_q;
  assign step1 = xfer_end && sel_q;
  assign fail0 = fail_now && !sel_q;
  assign fail1 = fail_now && sel_q;

  // R11: completion event per channel
  // R12: error event per channel
  assign ev = {fail1, step1 && last_sel, fail0, step0 && last_sel};

  // External request synchronisers; first stage feeds only the second
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      req_m_q <= 2'h0;
      req_s_q <= 2'h0;
    end
    else
    begin
      req_m_q <= {chan1_ext_request_in, chan0_ext_request_in};
      req_s_q <= req_m_q;
    end
  end

  // R16: after a clear, ignore request until seen low
  // Guards against the stale high still in the synchroniser
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wlow_q <= 2'h0;
    else
    begin
      wlow_q[0] <= (xfer_end && !sel_q && ext_sel) || (wlow_q[0] && req_s_q[0]);
      wlow_q[1] <= (xfer_end && sel_q && ext_sel) || (wlow_q[1] && req_s_q[1]);
    end
  end

  // Transfer engine: read source, then write destination
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= `DMAC_S_IDLE;
      sel_q <= 1'b0;
      last_srv_q <= 1'b1;
      bus_req <= 1'b0;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= 32'h0;
      mem_size <= `DMAC_SZ_BYTE;
      mem_wdata <= 32'h0;
      data_q <= 32'h0;
      chan0_request_clear_out <= 1'b0;
      chan1_request_clear_out <= 1'b0;
      chan0_last_transfer_out <= 1'b0;
      chan1_last_transfer_out <= 1'b0;
    end
    else
    begin
      chan0_request_clear_out <= 1'b0;
      chan1_request_clear_out <= 1'b0;
      case (st_q)
        `DMAC_S_IDLE:
        begin
          if (p0 || p1)
          begin
            sel_q <= pick1;
            last_srv_q <= pick1;
            bus_req <= 1'b1;
            st_q <= `DMAC_S_GRANT;
          end
        end
        `DMAC_S_GRANT:
        begin
          // A burst holding the bus still waits for an external request
          if (bus_grant && ok_sel)
          begin
            mem_req <= 1'b1;
            mem_write <= 1'b0;
            mem_addr <= csrc_sel;
            mem_size <= size_sel;
            // R17: flag start of the final transfer
            chan0_last_transfer_out <= last_sel && !sel_q;
            chan1_last_transfer_out <= last_sel && sel_q;
            st_q <= `DMAC_S_READ;
          end
        end
        `DMAC_S_READ:
        begin
          if (mem_ack)
          begin
            // R2: any endpoint pair, addresses only
            mem_write <= !mem_err;
            mem_req <= !mem_err;
            mem_addr <= cdst_sel;
            mem_wdata <= mem_rdata;
            data_q <= mem_rdata;
            if (mem_err)
            begin
              // R19: error drops the bus request
              bus_req <= 1'b0;
              chan0_last_transfer_out <= 1'b0;
              chan1_last_transfer_out <= 1'b0;
              st_q <= `DMAC_S_IDLE;
            end
            else
              st_q <= `DMAC_S_WRITE;
          end
        end
        `DMAC_S_WRITE:
        begin
          if (mem_ack)
          begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            chan0_last_transfer_out <= 1'b0;
            chan1_last_transfer_out <= 1'b0;
            // R16: acknowledge the external request
            chan0_request_clear_out <= !mem_err && ext_sel && !sel_q;
            chan1_request_clear_out <= !mem_err && ext_sel && sel_q;
            // R7: cycle steal releases after each transfer
            // R8: burst keeps request until the job ends
            // R19: count exhausted or error releases
            if (mem_err || last_sel || !burst_sel)
            begin
              bus_req <= 1'b0;
              st_q <= `DMAC_S_IDLE;
            end
            else
              st_q <= `DMAC_S_GRANT;
          end
        end
        default:
        begin
          bus_req <= 1'b0;
          mem_req <= 1'b0;
          st_q <= `DMAC_S_IDLE;
        end
      endcase
    end
  end

  // Register read mux from the address phase; unmapped reads as zero
  always @*
  begin
    rd_val = 32'h0;
    if (haddr[31:`DMAC_MAP_LO] != 25'h0)
      rd_val = 32'h0;
    else if (haddr[`DMAC_GLB_SEL])
    begin
      case (haddr[4:2])
        `DMAC_G_MODE: rd_val = {31'h0, rr_q};
        `DMAC_G_STAT: rd_val = {28'h0, stat_q};
        `DMAC_G_MASK: rd_val = {28'h0, mask_q};
        `DMAC_G_BUSY: rd_val = {30'h0, act1, act0};
        default: rd_val = 32'h0;
      endcase
    end
    else
    begin
      case (haddr[4:2])
        `DMAC_R_SRC: rd_val = haddr[`DMAC_CH_SEL] ? src1 : src0;
        `DMAC_R_DST: rd_val = haddr[`DMAC_CH_SEL] ? dst1 : dst0;
        `DMAC_R_CNT: rd_val = {{(32-CNT_W){1'b0}}, haddr[`DMAC_CH_SEL] ? cnt1 : cnt0};
        `DMAC_R_CFG: rd_val = {28'h0, haddr[`DMAC_CH_SEL] ? cfg1 : cfg0};
        `DMAC_R_CTL: rd_val = {31'h0, haddr[`DMAC_CH_SEL] ? act1 : act0};
        `DMAC_R_REM: rd_val = {{(32-CNT_W){1'b0}}, haddr[`DMAC_CH_SEL] ? rem1 : rem0};
        default: rd_val = 32'h0;
      endcase
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend_q <= 1'b0;
      ap_idx_q <= 5'h0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= ap_take && hwrite && (haddr[31:`DMAC_MAP_LO] == 25'h0);
      if (ap_take)
        ap_idx_q <= haddr[6:2];
      if (ap_take && !hwrite)
        hrdata <= rd_val;
    end
  end

  // Global mode, mask and sticky status; set wins over write-one-clear
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rr_q <= 1'b0;
      mask_q <= `DMAC_MASK_RST;
      stat_q <= `DMAC_ST_RST;
    end
    else
    begin
      if (wr_pend_q && ap_idx_q[4] && ap_idx_q[2:0] == `DMAC_G_MODE)
        rr_q <= hwdata[`DMAC_MODE_RR];
      if (wr_pend_q && ap_idx_q[4] && ap_idx_q[2:0] == `DMAC_G_MASK)
        mask_q <= hwdata[3:0];
      if (wr_pend_q && ap_idx_q[4] && ap_idx_q[2:0] == `DMAC_G_STAT)
        stat_q <= (stat_q & ~hwdata[3:0]) | ev;
      else
        stat_q <= stat_q | ev;
    end
  end

  // R13: one interrupt line per channel
  // R14: mask gates that channel's line and the summary irq
  always @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      chan0_irq <= 1'b0;
      chan1_irq <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      chan0_irq <= |(stat_q[1:0] & mask_q[1:0]);
      chan1_irq <= |(stat_q[3:2] & mask_q[3:2]);
      irq <= |(stat_q & mask_q);
    end
  end

endmodule // dmac_top

/* File: dmac_top_asserts.sv */
// Checker for dmac_top: bus ownership, access and device pin relations.
// Assumes it is bound to dmac_top and sees only its ports.
`timescale 1ns/1ps
module dmac_chk #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // System bus side
  input wire bus_req,
  input wire bus_grant,
  input wire mem_req,
  input wire mem_write,
  input wire [31:0] mem_addr,
  input wire mem_ack,
  input wire mem_err,
  // Device pins and interrupts
  input wire chan0_request_clear_out,
  input wire chan1_request_clear_out,
  input wire chan0_last_transfer_out,
  input wire chan1_last_transfer_out,
  input wire chan0_irq,
  input wire chan1_irq,
  input wire irq
);
  // One domain, so clock and reset are named once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_req_in_bus: assert property (mem_req |-> bus_req)
    else $error("access outside bus ownership");
  a_access_holds: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_write))
    else $error("access changed before its ack");
  a_grant_first: assert property ($rose(mem_req) |-> $past(bus_grant))
    else $error("access started without grant");
  a_drop_on_ack: assert property ($fell(bus_req) |-> $past(mem_ack))
    else $error("bus request dropped mid transfer");
  a_bus_gap: assert property ($rose(bus_req) |-> !mem_req)
    else $error("bus request raised during an access");
  a_err_stops: assert property (mem_ack && mem_err |=> !mem_req && !bus_req)
    else $error("engine kept going after error");
  a_clear_zero: assert property (chan0_request_clear_out |->
    $past(mem_ack && mem_write && !mem_err) ##1 !chan0_request_clear_out)
    else $error("channel zero clear pulse misplaced");
  a_clear_one: assert property (chan1_request_clear_out |->
    $past(mem_ack && mem_write && !mem_err) ##1 !chan1_request_clear_out)
    else $error("channel one clear pulse misplaced");
  a_last_in_access: assert property (chan0_last_transfer_out ||
    chan1_last_transfer_out |-> mem_req && !(chan0_last_transfer_out && chan1_last_transfer_out))
    else $error("last transfer flag outside an access");
  a_irq_any: assert property (irq == (chan0_irq || chan1_irq))
    else $error("summary interrupt disagrees with channels");
endmodule // dmac_chk

bind dmac_top dmac_chk #(.CNT_W(CNT_W)) u_chk (.sys_clk, .rst, .bus_req, .bus_grant,
  .mem_req, .mem_write, .mem_addr, .mem_ack, .mem_err, .chan0_request_clear_out,
  .chan1_request_clear_out, .chan0_last_transfer_out, .chan1_last_transfer_out,
  .chan0_irq, .chan1_irq, .irq);

/* File: test_two_channel_dma_controller.sv */
// Testbench for dmac_top: register-driven jobs checked at the pins.
// Assumes dmac_sys_model on the system side and one device on both request pins.
`timescale 1ns/1ps
module test_two_channel_dma_controller;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg hsel = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [3:0] ack_dly = 4'h2;
  reg ext0 = 1'b0;
  reg dev_on = 1'b0;
  reg [3:0] gap = 4'h0;
  reg br_d = 1'b0;
  reg l0_d = 1'b0;
  reg [3:0] seq = 4'h0;
  reg [31:0] last_a = 32'h0;
  reg [31:0] last_d = 32'h0;
  reg [1:0] last_sz = 2'h0;
  reg [31:0] v;
  integer n_wr = 0, n_fall = 0, n_clr = 0, n_last = 0, w0, f0, c0, l0;
  integer err_total = 0, n_compared = 0, i, ch;
  wire hreadyout, hresp, bus_req, bus_grant, mem_req, mem_write, mem_ack, mem_err;
  wire [31:0] hrdata, mem_addr, mem_wdata, mem_rdata;
  wire [1:0] mem_size;
  wire clr0, clr1, last0, last1, irq0, irq1, irq;
  dmac_top #(.CNT_W(16)) dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bus_req(bus_req),
    .bus_grant(bus_grant), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_err(mem_err),
    .mem_rdata(mem_rdata), .chan0_ext_request_in(ext0), .chan1_ext_request_in(ext0),
    .chan0_request_clear_out(clr0), .chan1_request_clear_out(clr1),
    .chan0_last_transfer_out(last0), .chan1_last_transfer_out(last1),
    .chan0_irq(irq0), .chan1_irq(irq1), .irq(irq));
  dmac_sys_model u_sys (.sys_clk(sys_clk), .rst(rst), .ack_dly(ack_dly), .bus_req(bus_req),
    .mem_req(mem_req), .mem_addr(mem_addr), .bus_grant(bus_grant), .mem_ack(mem_ack),
    .mem_err(mem_err), .mem_rdata(mem_rdata));
  // 100 MHz clock
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  // Observe writes, bus releases and last-transfer flags
  always @(posedge sys_clk)
  begin
    br_d <= bus_req;
    l0_d <= last0 | last1;
    if (br_d && !bus_req) n_fall <= n_fall + 1;
    if ((last0 | last1) && !l0_d) n_last <= n_last + 1;
    if (mem_ack && mem_write)
    begin
      n_wr <= n_wr + 1;
      last_a <= mem_addr;
      last_d <= mem_wdata;
      last_sz <= mem_size;
      seq <= {seq[2:0], mem_addr[13]};
    end
  end
  always @(posedge sys_clk)
    if (clr0 || clr1)
    begin
      ext0 <= 1'b0;
      gap <= 4'h6;
      n_clr <= n_clr + 1;
    end
    else if (gap != 4'h0) gap <= gap - 4'h1;
    else ext0 <= dev_on;
  task give_verdict;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // Wait for hready under a bound; a stuck slave ends the run
  task hwait;
    integer k;
    begin
      k = 0;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1 && k < 20)
      begin
        @(posedge sys_clk);
        k = k + 1;
      end
      if (hreadyout !== 1'b1)
      begin
        err_total = err_total + 1;
        give_verdict;
      end
    end
  endtask
  task wr(input [31:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= 1'b1;
      hwait;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      hwait;
    end
  endtask
  // Leading idle cycle avoids reading stale data after a write
  task rd(input [31:0] a, output [31:0] d);
    begin
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= 1'b0;
      hwait;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwait;
      d = hrdata;
    end
  endtask
  task prog(input [31:0] b, input [31:0] s, input [31:0] d, input [31:0] n, input [31:0] c);
    begin
      wr(b, s);
      wr(b + 32'h4, d);
      wr(b + 32'h8, n);
      wr(b + 32'hC, c);
    end
  endtask
  // Poll the busy register until the given channels are idle
  task idle(input [31:0] m);
    begin
      for (i = 0; i < 300 && (i == 0 || (v & m) != 32'h0); i = i + 1)
        rd(32'h4C, v);
      if ((v & m) != 32'h0)
      begin
        err_total = err_total + 1;
        give_verdict;
      end
      repeat (2) @(posedge sys_clk);
      w0 = n_wr - w0;
      f0 = n_fall - f0;
      $display("job done");
    end
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rd(32'h0C, v);
    chk("cfg0", v, 32'h0);
    rd(32'h48, v);
    chk("mask", v, 32'h0);
    wr(32'h80, 32'hFFFFFFFF);
    rd(32'h80, v);
    chk("unmapped", v, 32'h0);
    chk("resp", {31'h0, hresp}, 32'h0);
    // Software word job, three transfers, cycle steal
    wr(32'h48, 32'h3);
    prog(32'h0, 32'h100, 32'h1000, 32'h2, 32'h2);
    w0 = n_wr;
    f0 = n_fall;
    wr(32'h10, 32'h1);
    wr(32'hC, 32'h0);
    idle(32'h1);
    chk("writes", w0, 32'h3);
    chk("releases", f0, 32'h3);
    chk("dst", last_a, 32'h1008);
    chk("data", last_d, 32'h5A5A0108);
    rd(32'h44, v);
    chk("done", v, 32'h1);
    chk("irq0", {31'h0, irq0}, 32'h1);
    wr(32'h44, 32'hF);
    rd(32'h44, v);
    chk("irq", {31'h0, irq}, 32'h0);
    // Byte and half units, prompt memory
    ack_dly <= 4'h0;
    for (c0 = 0; c0 < 2; c0 = c0 + 1)
    begin
      prog(32'h0, 32'h200, 32'h1000, 32'h1, c0);
      wr(32'h10, 32'h1);
      idle(32'h1);
      chk("unit", last_a, 32'h1000 + (32'h1 << c0));
      chk("size", {30'h0, last_sz}, c0);
    end
    // Burst on channel one, slow memory
    ack_dly <= 4'h4;
    prog(32'h20, 32'h300, 32'h2000, 32'h3, 32'h6);
    w0 = n_wr;
    f0 = n_fall;
    wr(32'h30, 32'h1);
    idle(32'h2);
    chk("burst writes", w0, 32'h4);
    chk("burst releases", f0, 32'h1);
    // Both channels at once: fixed then round robin
    prog(32'h0, 32'h100, 32'h1000, 32'h1, 32'h2);
    prog(32'h20, 32'h300, 32'h2000, 32'h1, 32'h2);
    for (c0 = 0; c0 < 2; c0 = c0 + 1)
    begin
      wr(32'h40, c0);
      wr(32'h10, 32'h1);
      wr(32'h30, 32'h1);
      idle(32'h3);
      chk("order", {28'h0, seq}, (c0 == 0) ? 32'h3 : 32'h5);
    end
    // External pacing on each channel in turn
    ack_dly <= 4'h1;
    for (ch = 0; ch < 2; ch = ch + 1)
    begin
      prog(ch * 32'h20, 32'h400, 32'h1000, 32'h1, 32'hA);
      wr(ch * 32'h20 + 32'h10, 32'h1);
      repeat (30) @(posedge sys_clk);
      chk("no request", {31'h0, bus_req}, 32'h0);
      c0 = n_clr;
      l0 = n_last;
      dev_on <= 1'b1;
      idle(32'h3);
      dev_on <= 1'b0;
      chk("clears", n_clr - c0, 32'h2);
      chk("last flag", n_last - l0, 32'h1);
    end
    // Read error on masked channel one
    wr(32'h44, 32'hF);
    wr(32'h48, 32'h1);
    prog(32'h20, 32'hEEEE0000, 32'h2000, 32'h3, 32'h2);
    w0 = n_wr;
    wr(32'h30, 32'h1);
    idle(32'h2);
    chk("no writes", w0, 32'h0);
    rd(32'h44, v);
    chk("err", v & 32'hC, 32'h8);
    chk("masked", {30'h0, irq1, irq}, 32'h0);
    wr(32'h48, 32'hC);
    rd(32'h44, v);
    chk("irqs", {30'h0, irq1, irq0}, 32'h2);
    give_verdict;
  end
endmodule // test_two_channel_dma_controller
